// File: inc/tmr_pkg.sv
// Package with register offsets, field positions, reset values and timing constants
package tmr_pkg;
	// Register offsets (word index on the plain register port)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_MODE = 4'h1;
	localparam logic [3:0] ADDR_MODE1 = 4'h2;
	localparam logic [3:0] ADDR_COUNT_LOW = 4'h3;
	localparam logic [3:0] ADDR_COUNT_HIGH = 4'h4;
	localparam logic [3:0] ADDR_RELOAD_LOW = 4'h5;
	localparam logic [3:0] ADDR_RELOAD_HIGH = 4'h6;
	// Control register fields
	localparam int CTRL_OVF = 7;
	localparam int CTRL_EXT = 6;
	localparam int CTRL_B5 = 5;
	localparam int CTRL_B4 = 4;
	localparam int CTRL_FALL_EN = 3;
	localparam int CTRL_RUN_HIGH = 2;
	localparam int CTRL_CT = 1;
	localparam int CTRL_CPRL = 0;
	// Mode register fields
	localparam int MODE_SPLIT = 7;
	localparam int MODE_B6 = 6;
	localparam int MODE_RISE_EN = 5;
	localparam int MODE_X12 = 4;
	localparam int MODE_RUN_LOW = 3;
	localparam int MODE_RUN_LOW_CLR = 2;
	localparam int MODE_CKO_EN = 1;
	localparam int MODE_MS0 = 0;
	// Mode register 1 fields
	localparam int MODE1_LOW_CS = 7;
	localparam int MODE1_IRQ_MASK = 6;
	localparam int MODE1_BANK = 5;
	localparam int MODE1_CKS = 4;
	localparam int MODE1_MS1 = 3;
	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Prescale ratios and the duty mode code
	localparam int SYS_DIV12 = 12;
	localparam int SYS_DIV2 = 2;
	localparam logic [2:0] MODE_DUTY = 3'h6;
	// Duty capture phases
	typedef enum logic [1:0] {
		DUTY_IDLE = 2'b00,
		DUTY_WAIT_FIRST = 2'b01,
		DUTY_WAIT_SECOND = 2'b10,
		DUTY_WAIT_THIRD = 2'b11
	} duty_state_t;
endpackage

// File: src/tmr_prescale.sv
// System clock prescaler producing divide-by-2 and divide-by-12 enable pulses
module tmr_prescale
	import tmr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	output logic div2_o,
	output logic div12_o
);
	logic [3:0] cnt_q;
	logic half_q;

	// Free running divide-by-12 counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 4'h0;
		end else if (cnt_q == 4'(SYS_DIV12 - 1)) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// Divide-by-2 toggle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
		end
	end

	assign div2_o = half_q;
	assign div12_o = (cnt_q == 4'(SYS_DIV12 - 1));
endmodule // tmr_prescale

// File: src/timer_baud_clockout_duty.sv
// Second timer: split duty capture, baud generation and programmable clock output
// Overview of operation
// R01: Split plus duty mode code makes two 8-bit counters; the high one does duty capture.
// R02: First trigger edge must be rising; it starts counting, sets no flag.
// R03: Second edge copies high counter to high reload; flag if fall enable.
// R04: Third edge clears high run bit; flag if rise enable set.
// R05: Transmit and receive clock selects pick timer 1 or this overflow.
// R06: Baud generation is active only while a clock select is set.
// R07: Baud mode high rollover reloads all sixteen bits from reload registers.
// R08: Baud mode counts at half system clock or from the count pin.
// R09: Baud mode rollover still sets overflow flag; mask bit gates interrupt.
// R10: Baud mode falling trigger sets external flag without any reload.
// R11: Software should not access counter bytes while baud generation runs.
// R12: Software may read reloads in baud mode, should stop before writing.
// R13: Split mode 0: low byte is 8-bit baud source, high byte auto-reloads.
// R14: Capture select 0 and clock-out enable give a 50% clock output.
// R15: Sixteen-bit clock-out counts at system_clock/2, /12 or /1, reloads on overflow.
// R16: Clock-out frequency is input clock over 2*(65536 - reload).
// R17: Clock-out overflows set overflow flag; baud may share the rate.
// R18: Software sets source, reloads, counter, clock-out enable, then run.
// R19: Split clock output toggles on low overflow, input over 2*(256 - reload).
// R20: Software configures low source and bytes before setting low run.
// R21: Split clock-out low overflows set low overflow flag; enable gates only the interrupt.
// R22: Bank select maps two control bits to clock selects or low flag set.
// R23: Clock-out pin inverts on each qualifying overflow, giving square wave.
module timer_baud_clockout_duty
	import tmr_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RSTN_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic COUNT_PIN_I,
	input wire logic TRIGGER_PIN_I,
	input wire logic TIMER1_OVF_I,
	output logic [7:0] RDATA_O,
	output logic CLOCK_OUT_PIN_O,
	output logic RX_BAUD_O,
	output logic TX_BAUD_O,
	output logic OVERFLOW_EVENT_O,
	output logic IRQ_O
);
	logic [7:0] ctrl_q;
	logic [7:0] mode_q;
	logic [7:0] mode1_q;
	logic rx_clock_select_q;
	logic tx_clock_select_q;
	logic low_x12_q;
	logic low_overflow_flag_q;
	logic low_overflow_irq_enable_q;
	logic trig_invert_q;
	logic [7:0] count_low_q;
	logic [7:0] count_high_q;
	logic [7:0] reload_low_q;
	logic [7:0] reload_high_q;
	logic trig_prev_q;
	duty_state_t duty_q;
	logic div2;
	logic div12;
	logic [2:0] mode_code;
	logic split_enable;
	logic baud_mode;
	logic duty_mode;
	logic trig_now;
	logic rise_edge;
	logic fall_edge;
	logic ext_set;
	logic tick_high;
	logic tick_low;
	logic run_high;
	logic run_low;
	logic ovf16;
	logic ovf_low;
	logic ovf_high;
	logic overflow_event;
	logic duty_capture;
	logic duty_stop;
	logic wr_ctrl;

	// Shared divider for the slow enables
	tmr_prescale u_prescale (
		.clk_i(REF_CLK_I),
		.rst_n_i(RSTN_I),
		.div2_o(div2),
		.div12_o(div12)
	);

	// Select a clock enable from the three-bit source code
	function automatic logic pick_tick(input logic [2:0] sel, input logic d2, input logic d12,
			input logic pin_rise, input logic low_ovf);
		case (sel)
			3'h0: pick_tick = d12;
			3'h1: pick_tick = pin_rise;
			3'h2: pick_tick = 1'b1;
			3'h3: pick_tick = low_ovf;
			default: pick_tick = d2;
		endcase
	endfunction

	logic pin_prev_q;
	logic pin_rise;
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pin_prev_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= COUNT_PIN_I;
			trig_prev_q <= trig_now;
		end
	end
	assign pin_rise = COUNT_PIN_I & ~pin_prev_q;

	// Mode decoding
	assign mode_code = {mode1_q[MODE1_MS1], ctrl_q[CTRL_CPRL], mode_q[MODE_MS0]};
	assign split_enable = mode_q[MODE_SPLIT];
	assign baud_mode = (rx_clock_select_q | tx_clock_select_q) & ~split_enable; // see R06
	assign duty_mode = split_enable && (mode_code == MODE_DUTY); // see R01
	assign run_high = ctrl_q[CTRL_RUN_HIGH];
	assign run_low = mode_q[MODE_RUN_LOW];
	assign trig_now = TRIGGER_PIN_I ^ trig_invert_q;
	assign rise_edge = trig_now & ~trig_prev_q;
	assign fall_edge = ~trig_now & trig_prev_q;

	// Tick selection; baud mode forces half system clock unless the pin is chosen
	always_comb begin
		if (baud_mode) begin
			tick_high = ctrl_q[CTRL_CT] ? pin_rise : div2; // see R08
		end else if (ctrl_q[CTRL_CPRL] == 1'b0 && mode_q[MODE_CKO_EN] && !split_enable &&
				mode_q[MODE_X12] == 1'b0 && ctrl_q[CTRL_CT] == 1'b0 &&
				mode1_q[MODE1_CKS]) begin
			tick_high = div2; // see R15
		end else begin
			tick_high = pick_tick({mode1_q[MODE1_CKS], mode_q[MODE_X12], ctrl_q[CTRL_CT]},
				div2, div12, pin_rise, ovf_low);
		end
		tick_low = low_x12_q ? 1'b1 : div12;
	end

	// Overflow detection for each arrangement
	assign ovf16 = !split_enable && run_high && tick_high && ({count_high_q, count_low_q} == 16'hffff);
	assign ovf_low = split_enable && run_low && tick_low && (count_low_q == 8'hff);
	assign ovf_high = split_enable && run_high && tick_high && (count_high_q == 8'hff) && !duty_mode;
	assign overflow_event = split_enable ? ovf_low : ovf16;

	// Duty capture edge sequencing
	assign duty_capture = duty_mode && (duty_q == DUTY_WAIT_SECOND) && fall_edge;
	assign duty_stop = duty_mode && (duty_q == DUTY_WAIT_THIRD) && rise_edge;
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			duty_q <= DUTY_IDLE;
		end else begin
			case (duty_q)
				DUTY_IDLE: if (duty_mode && run_high) duty_q <= DUTY_WAIT_FIRST;
				DUTY_WAIT_FIRST: if (!duty_mode || !run_high) duty_q <= DUTY_IDLE;
					else if (rise_edge) duty_q <= DUTY_WAIT_SECOND; // see R02
				DUTY_WAIT_SECOND: if (!duty_mode || !run_high) duty_q <= DUTY_IDLE;
					else if (fall_edge) duty_q <= DUTY_WAIT_THIRD;
				DUTY_WAIT_THIRD: if (!duty_mode || !run_high || rise_edge) duty_q <= DUTY_IDLE;
				default: duty_q <= DUTY_IDLE;
			endcase
		end
	end

	// External event: falling needs fall enable, rising needs rise enable
	always_comb begin
		if (duty_mode) begin
			ext_set = (duty_capture && ctrl_q[CTRL_FALL_EN]) || // see R03
				(duty_stop && mode_q[MODE_RISE_EN]); // see R04
		end else begin
			ext_set = (fall_edge && ctrl_q[CTRL_FALL_EN]) || // see R10
				(rise_edge && mode_q[MODE_RISE_EN]);
		end
	end

	assign wr_ctrl = WR_I && (ADDR_I == ADDR_CTRL);

	// Control register; hardware sets win over software clears
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ctrl_q <= RESET_BYTE;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= {WDATA_I[7:6], 2'b00, WDATA_I[3:0]};
			end
			if (duty_stop) ctrl_q[CTRL_RUN_HIGH] <= 1'b0; // see R04
			if (ovf16 || ovf_high) ctrl_q[CTRL_OVF] <= 1'b1; // see R09 R17 R13
			if (ext_set) ctrl_q[CTRL_EXT] <= 1'b1;
		end
	end

	// Banked bits behind the three shared positions
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rx_clock_select_q <= 1'b0;
			tx_clock_select_q <= 1'b0;
			low_x12_q <= 1'b0;
			low_overflow_flag_q <= 1'b0;
			low_overflow_irq_enable_q <= 1'b0;
			trig_invert_q <= 1'b0;
		end else begin
			if (wr_ctrl && !mode1_q[MODE1_BANK]) begin
				rx_clock_select_q <= WDATA_I[CTRL_B5]; // see R22
				tx_clock_select_q <= WDATA_I[CTRL_B4];
			end
			if (wr_ctrl && mode1_q[MODE1_BANK]) begin
				low_overflow_flag_q <= WDATA_I[CTRL_B5]; // see R22
				low_overflow_irq_enable_q <= WDATA_I[CTRL_B4];
			end
			if (WR_I && ADDR_I == ADDR_MODE) begin
				if (mode1_q[MODE1_BANK]) trig_invert_q <= WDATA_I[MODE_B6];
				else low_x12_q <= WDATA_I[MODE_B6];
			end
			if (ovf_low) low_overflow_flag_q <= 1'b1; // see R13 R21
		end
	end

	// Mode registers
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			mode_q <= RESET_BYTE;
			mode1_q <= RESET_BYTE;
		end else begin
			if (WR_I && ADDR_I == ADDR_MODE) mode_q <= {WDATA_I[7], 1'b0, WDATA_I[5:0]};
			if (WR_I && ADDR_I == ADDR_MODE1) mode1_q <= WDATA_I;
			if (ovf_high && mode_q[MODE_RUN_LOW_CLR]) mode_q[MODE_RUN_LOW] <= 1'b0;
		end
	end

	// Counters and reload registers
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			count_low_q <= RESET_BYTE;
			count_high_q <= RESET_BYTE;
			reload_low_q <= RESET_BYTE;
			reload_high_q <= RESET_BYTE;
		end else begin
			if (WR_I && ADDR_I == ADDR_COUNT_LOW) count_low_q <= WDATA_I;
			if (WR_I && ADDR_I == ADDR_COUNT_HIGH) count_high_q <= WDATA_I;
			if (WR_I && ADDR_I == ADDR_RELOAD_LOW) reload_low_q <= WDATA_I;
			if (WR_I && ADDR_I == ADDR_RELOAD_HIGH) reload_high_q <= WDATA_I;
			if (!split_enable) begin
				if (ovf16) begin
					// Reload in auto-reload, baud and clock-out arrangements
					count_high_q <= reload_high_q; // see R07 R15 R16
					count_low_q <= reload_low_q;
				end else if (run_high && tick_high) begin
					{count_high_q, count_low_q} <= {count_high_q, count_low_q} + 16'h0001;
				end
			end else begin
				if (ovf_low) count_low_q <= reload_low_q; // see R13 R19
				else if (run_low && tick_low) count_low_q <= count_low_q + 8'h01;
				if (duty_capture) reload_high_q <= count_high_q; // see R03
				if (duty_mode) begin
					// Counts only between first edge and third edge
					if (duty_q == DUTY_WAIT_SECOND || duty_q == DUTY_WAIT_THIRD) begin
						if (run_high && tick_high && !duty_stop)
							count_high_q <= count_high_q + 8'h01; // see R01
					end
				end else if (ovf_high) begin
					count_high_q <= reload_high_q; // see R13
				end else if (run_high && tick_high) begin
					count_high_q <= count_high_q + 8'h01;
				end
			end
		end
	end

	// Clock output toggles on each qualifying overflow; disabled pin rests low
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			CLOCK_OUT_PIN_O <= 1'b0;
		end else if (!mode_q[MODE_CKO_EN] || ctrl_q[CTRL_CPRL]) begin
			CLOCK_OUT_PIN_O <= 1'b0;
		end else if (overflow_event) begin
			CLOCK_OUT_PIN_O <= ~CLOCK_OUT_PIN_O; // see R14 R19 R23
		end
	end

	// Baud pulses to the serial engine, one cycle late to come from flip-flops
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			RX_BAUD_O <= 1'b0;
			TX_BAUD_O <= 1'b0;
			OVERFLOW_EVENT_O <= 1'b0;
			IRQ_O <= 1'b0;
		end else begin
			RX_BAUD_O <= rx_clock_select_q ? overflow_event : TIMER1_OVF_I; // see R05
			TX_BAUD_O <= tx_clock_select_q ? overflow_event : TIMER1_OVF_I; // see R05
			OVERFLOW_EVENT_O <= overflow_event;
			IRQ_O <= (ctrl_q[CTRL_OVF] && !mode1_q[MODE1_IRQ_MASK]) || ctrl_q[CTRL_EXT] ||
				(low_overflow_flag_q && low_overflow_irq_enable_q); // see R09 R21
		end
	end

	// Read port; data stand the cycle after the strobe
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			RDATA_O <= RESET_BYTE;
		end else if (RD_I) begin
			case (ADDR_I)
				ADDR_CTRL: RDATA_O <= mode1_q[MODE1_BANK] ?
					{ctrl_q[7:6], low_overflow_flag_q, low_overflow_irq_enable_q, ctrl_q[3:0]} :
					{ctrl_q[7:6], rx_clock_select_q, tx_clock_select_q, ctrl_q[3:0]};
				ADDR_MODE: RDATA_O <= {mode_q[7], mode1_q[MODE1_BANK] ? trig_invert_q : low_x12_q,
					mode_q[5:0]};
				ADDR_MODE1: RDATA_O <= mode1_q;
				ADDR_COUNT_LOW: RDATA_O <= count_low_q;
				ADDR_COUNT_HIGH: RDATA_O <= count_high_q;
				ADDR_RELOAD_LOW: RDATA_O <= reload_low_q;
				ADDR_RELOAD_HIGH: RDATA_O <= reload_high_q;
				default: RDATA_O <= RESET_BYTE;
			endcase
		end else begin
			RDATA_O <= RESET_BYTE;
		end
	end
endmodule // timer_baud_clockout_duty

// File: dv/tmr_props.sv
// Port-level assertions for the second timer
module tmr_props
	import tmr_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RSTN_I,
	input wire logic [3:0] ADDR_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic TIMER1_OVF_I,
	input wire logic [7:0] RDATA_O,
	input wire logic CLOCK_OUT_PIN_O,
	input wire logic RX_BAUD_O,
	input wire logic TX_BAUD_O,
	input wire logic OVERFLOW_EVENT_O,
	input wire logic IRQ_O
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RSTN_I);
	logic [1:0] ovf_q;
	logic [1:0] wr_q;
	// Short history of overflows and writes, the only legal causes of a pin change
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ovf_q <= 2'b00;
			wr_q <= 2'b00;
		end else begin
			ovf_q <= {ovf_q[0], OVERFLOW_EVENT_O};
			wr_q <= {wr_q[0], WR_I};
		end
	end
	a_reset_quiet: assert property ($rose(RSTN_I) |-> !CLOCK_OUT_PIN_O && !IRQ_O && !TX_BAUD_O)
		else $error("outputs active right after reset");
	a_reset_rdata: assert property ($rose(RSTN_I) |-> RDATA_O == 8'h00 && !OVERFLOW_EVENT_O)
		else $error("read data or overflow active right after reset");
	a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data outside the read answer cycle");
	a_rd_unmapped: assert property (RD_I && ADDR_I > ADDR_RELOAD_HIGH |=> RDATA_O == 8'h00)
		else $error("unmapped index read nonzero");
	a_tx_source: assert property (TX_BAUD_O |-> $past(TIMER1_OVF_I) || OVERFLOW_EVENT_O)
		else $error("transmit baud pulse without a source overflow");
	a_rx_source: assert property (RX_BAUD_O |-> $past(TIMER1_OVF_I) || OVERFLOW_EVENT_O)
		else $error("receive baud pulse without a source overflow");
	a_cko_rise: assert property ($rose(CLOCK_OUT_PIN_O) |-> OVERFLOW_EVENT_O || ovf_q != 2'b00)
		else $error("clock output rose without an overflow");
	a_cko_cause: assert property ($changed(CLOCK_OUT_PIN_O) |-> OVERFLOW_EVENT_O || ovf_q != 2'b00
		|| wr_q != 2'b00)
		else $error("clock output moved without overflow or write");
	// Main scenarios reached
	c_tx: cover property (TX_BAUD_O && !$past(TIMER1_OVF_I));
	c_rx: cover property (RX_BAUD_O);
	c_cko: cover property ($rose(CLOCK_OUT_PIN_O));
	c_irq: cover property ($rose(IRQ_O));
endmodule // tmr_props

// File: dv/serial_sink.sv
// Serial port engine stand-in that consumes both baud pulse streams
module serial_sink (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rx_baud_i,
	input wire logic tx_baud_i,
	output int rx_count_o,
	output int tx_count_o,
	output int tx_gap_o
);
	int now_q;
	int last_q;
	// Count pulses and keep the spacing of the last two transmit ticks
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			now_q <= 0;
			last_q <= 0;
			rx_count_o <= 0;
			tx_count_o <= 0;
			tx_gap_o <= 0;
		end else begin
			now_q <= now_q + 1;
			if (rx_baud_i) begin
				rx_count_o <= rx_count_o + 1;
			end
			if (tx_baud_i) begin
				tx_count_o <= tx_count_o + 1;
				tx_gap_o <= now_q - last_q;
				last_q <= now_q;
			end
		end
	end
endmodule // serial_sink

// File: dv/tb.sv
// Self-checking bench for the second timer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr_pkg::*;
	logic REF_CLK_I = 1'b0;
	logic RSTN_I = 1'b0;
	logic [3:0] ADDR_I = 4'h0;
	logic [7:0] WDATA_I = 8'h00;
	logic WR_I = 1'b0;
	logic RD_I = 1'b0;
	logic COUNT_PIN_I = 1'b0;
	logic TRIGGER_PIN_I = 1'b0;
	logic TIMER1_OVF_I = 1'b0;
	logic [7:0] RDATA_O;
	logic CLOCK_OUT_PIN_O, RX_BAUD_O, TX_BAUD_O, OVERFLOW_EVENT_O, IRQ_O;
	int n_mismatch = 0;
	int checks_done = 0;
	integer seed = 32'hb39d949d;
	int rx_count, tx_count, tx_gap, hp, r0, t0, o0, n_ovf, hi, cyc, mdl[7];
	logic [7:0] rv;
	logic [2:0] cfg;
	timer_baud_clockout_duty DUT (.REF_CLK_I, .RSTN_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
		.COUNT_PIN_I, .TRIGGER_PIN_I, .TIMER1_OVF_I, .RDATA_O, .CLOCK_OUT_PIN_O, .RX_BAUD_O,
		.TX_BAUD_O, .OVERFLOW_EVENT_O, .IRQ_O);
	serial_sink u_sink (.clk_i(REF_CLK_I), .rst_n_i(RSTN_I), .rx_baud_i(RX_BAUD_O),
		.tx_baud_i(TX_BAUD_O), .rx_count_o(rx_count), .tx_count_o(tx_count), .tx_gap_o(tx_gap));
	// 25 MHz system clock and a cycle count for edge timing
	always #20 REF_CLK_I = ~REF_CLK_I;
	always @(posedge REF_CLK_I) cyc <= cyc + 1;
	// Overflow pulses seen at the port, compared against the baud rate
	always @(posedge REF_CLK_I) if (OVERFLOW_EVENT_O) n_ovf <= n_ovf + 1;
	// Count pin rises every four clocks; timer 1 overflows every fifty
	always begin
		repeat (2) @(posedge REF_CLK_I);
		COUNT_PIN_I <= ~COUNT_PIN_I;
	end
	always begin
		repeat (49) @(posedge REF_CLK_I);
		TIMER1_OVF_I <= 1'b1;
		@(posedge REF_CLK_I);
		TIMER1_OVF_I <= 1'b0;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge REF_CLK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge REF_CLK_I);
		WR_I <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge REF_CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge REF_CLK_I);
		RD_I <= 1'b0;
		#1;
		d = RDATA_O;
	endtask
	// Cycles until the clock output next changes, bounded
	task automatic gap(output int n);
		logic p;
		n = 0;
		p = CLOCK_OUT_PIN_O;
		while (CLOCK_OUT_PIN_O === p && n < 3000) begin
			@(posedge REF_CLK_I);
			#1;
			n++;
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Watchdog: the full sequence needs well under ten thousand clocks
	initial begin
		repeat (30000) @(posedge REF_CLK_I);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge REF_CLK_I);
		RSTN_I <= 1'b1;
		// An ignored write to an unmapped index, then reset values read back
		wr(4'h9, 8'h5a);
		for (int a = 0; a < 10; a++) begin
			rd(a[3:0], rv);
			chk("reset or unmapped read", rv, 16'h0);
		end
		// Random reload bytes read back against the model
		for (int i = 0; i < 6; i++) begin
			mdl[5 + i % 2] = $random(seed) & 8'hff;
			wr(4'(5 + i % 2), 8'(mdl[5 + i % 2]));
			rd(4'(5 + i % 2), rv);
			chk("reload readback", rv, 16'(mdl[5 + i % 2]));
		end
		// Sixteen-bit clock output at /2, /12 and /1, sixteen counts per overflow
		for (int k = 0; k < 3; k++) begin
			cfg = k == 0 ? 3'b100 : (k == 1 ? 3'b000 : 3'b010);
			wr(ADDR_CTRL, 8'h00);
			wr(ADDR_MODE1, {3'b000, cfg[2], 4'h0});
			wr(ADDR_RELOAD_LOW, 8'hf0);
			wr(ADDR_RELOAD_HIGH, 8'hff);
			wr(ADDR_COUNT_LOW, 8'hf0);
			wr(ADDR_COUNT_HIGH, 8'hff);
			wr(ADDR_MODE, {3'b000, cfg[1], 4'b0010});
			wr(ADDR_CTRL, {6'b000001, cfg[0], 1'b0});
			gap(hp);
			gap(hp);
			chk("clock out half period", 16'(hp), 16'(16 * (k == 0 ? 2 : (k == 1 ? 12 : 1))));
		end
		rd(ADDR_CTRL, rv);
		chk("overflow flag in clock out", 16'(rv[7]), 16'h1);
		chk("overflow irq", 16'(IRQ_O), 16'h1);
		// Mask bit alone must silence the overflow interrupt
		wr(ADDR_MODE1, 8'h40);
		repeat (2) @(posedge REF_CLK_I);
		chk("overflow irq masked", 16'(IRQ_O), 16'h0);
		// Split clock output from the low byte at system clock, reload f6
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_MODE1, 8'h00);
		wr(ADDR_RELOAD_LOW, 8'hf6);
		wr(ADDR_COUNT_LOW, 8'hf6);
		wr(ADDR_MODE, 8'hc2);
		wr(ADDR_MODE, 8'hca);
		gap(hp);
		gap(hp);
		chk("split half period", 16'(hp), 16'd10);
		wr(ADDR_MODE1, 8'h20);
		rd(ADDR_CTRL, rv);
		chk("low overflow flag", 16'(rv[5]), 16'h1);
		wr(ADDR_CTRL, 8'h10);
		repeat (12) @(posedge REF_CLK_I);
		chk("low irq enabled", 16'(IRQ_O), 16'h1);
		wr(ADDR_CTRL, 8'h00);
		repeat (12) @(posedge REF_CLK_I);
		chk("low irq masked", 16'(IRQ_O), 16'h0);
		// Baud mode: transmit from own overflow at half clock, receive from timer 1
		wr(ADDR_MODE1, 8'h00);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_RELOAD_LOW, 8'hec);
		wr(ADDR_RELOAD_HIGH, 8'hff);
		wr(ADDR_COUNT_LOW, 8'hec);
		wr(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_CTRL, 8'h1c);
		TRIGGER_PIN_I <= 1'b1;
		repeat (100) @(posedge REF_CLK_I);
		r0 = rx_count;
		t0 = tx_count;
		o0 = n_ovf;
		repeat (150) @(posedge REF_CLK_I);
		TRIGGER_PIN_I <= 1'b0;
		repeat (250) @(posedge REF_CLK_I);
		chk("timer 1 receive pulses", 16'(rx_count - r0), 16'd8);
		chk("own transmit pulses", 16'(tx_count - t0), 16'd10);
		chk("overflow pulses", 16'(n_ovf - o0), 16'd10);
		chk("transmit spacing", 16'(tx_gap), 16'd40);
		rd(ADDR_CTRL, rv);
		chk("flags in baud mode", 16'(rv[7:6]), 16'h3);
		// Both selects from the count pin: twenty pin rises per overflow
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h36);
		repeat (200) @(posedge REF_CLK_I);
		r0 = rx_count;
		t0 = tx_count;
		repeat (400) @(posedge REF_CLK_I);
		chk("pin receive pulses", 16'(rx_count - r0), 16'd5);
		chk("pin transmit spacing", 16'(tx_gap), 16'd80);
		// Split duty capture with the high counter at system clock
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_COUNT_HIGH, 8'h00);
		wr(ADDR_COUNT_LOW, 8'h00);
		wr(ADDR_MODE1, 8'h08);
		wr(ADDR_MODE, 8'hb0);
		wr(ADDR_CTRL, 8'h0d);
		hi = 20 + {$random(seed)} % 40;
		repeat (5) @(posedge REF_CLK_I);
		t0 = cyc;
		TRIGGER_PIN_I <= 1'b1;
		rd(ADDR_CTRL, rv);
		chk("no flag on first edge", 16'(rv[6]), 16'h0);
		while (cyc < t0 + hi) @(posedge REF_CLK_I);
		TRIGGER_PIN_I <= 1'b0;
		rd(ADDR_CTRL, rv);
		chk("flag on second edge", 16'(rv[6]), 16'h1);
		wr(ADDR_CTRL, 8'h0d);
		while (cyc < t0 + hi + 60) @(posedge REF_CLK_I);
		TRIGGER_PIN_I <= 1'b1;
		repeat (10) @(posedge REF_CLK_I);
		rd(ADDR_CTRL, rv);
		chk("run cleared and flag", 16'(rv), 16'h49);
		rd(ADDR_RELOAD_HIGH, rv);
		chk("high time", 16'(rv >= hi - 1 && rv <= hi + 1), 16'h1);
		rd(ADDR_COUNT_HIGH, rv);
		chk("cycle time", 16'(rv >= hi + 59 && rv <= hi + 61), 16'h1);
		print_verdict();
	end
endmodule // tb
bind timer_baud_clockout_duty tmr_props u_props (.REF_CLK_I, .RSTN_I, .ADDR_I, .WR_I, .RD_I,
	.TIMER1_OVF_I, .RDATA_O, .CLOCK_OUT_PIN_O, .RX_BAUD_O, .TX_BAUD_O, .OVERFLOW_EVENT_O, .IRQ_O);
